// File: inc/link_consts.vh
// Constants for the selection, front-end and oscillator divider logic
`ifndef LINK_CONSTS_VH
`define LINK_CONSTS_VH

`define CLK_PERIOD_NS   10
`define HOLD_OFF_NS     100
`define HOLD_OFF_CYC    ((`HOLD_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CNT_W      4
`define CFG_DELAY_US    2000
`define CFG_DELAY_CYC   ((`CFG_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define DELAY_CNT_W     18

`define CMD_SKIP        8'hCC
`define CMD_RESUME      8'hA5

`define UNLOCK_LEN      3'h6
`define UNLOCK_B0       8'hDD
`define UNLOCK_B1       8'h01
`define UNLOCK_B2       8'h3D
`define UNLOCK_B3       8'h75
`define UNLOCK_B4       8'hF9
`define UNLOCK_B5       8'hC3

`define SET_B0          8'hAA
`define SET_B1          8'h85
`define SET_DIVIDE_BY_TWO        8'h41
`define SET_DIVIDE_BY_TWO_TAIL   8'h02
`define SET_DIVIDE_BY_FOUR        8'h42
`define SET_DIVIDE_BY_EIGHT        8'h43
`define BIT_SEQ         7'h02
`define BIT_SEQ_LEN     3'h7

`define DIV_ONE         2'h0
`define DIV_TWO         2'h1
`define DIV_FOUR        2'h2
`define DIV_EIGHT       2'h3

`endif

// File: rtl/line_front_end.v
// Noise-tolerant receive front end of one line port
`timescale 1ns/1ps
`include "link_consts.vh"

module line_front_end (
	// Clock and reset
	input  wire i_clk,
	input  wire i_rst_n,
	// Comparator levels
	input  wire i_above_high,
	input  wire i_below_low,
	// Receiver state
	output reg  o_line_high,
	output reg  o_slot_start
);

	// Hold-off counted in whole clock cycles, rounded up
	localparam integer           HOLD_CYC = `HOLD_OFF_CYC;
	localparam [`HOLD_CNT_W-1:0] HOLD_END = HOLD_CYC[`HOLD_CNT_W-1:0];

	reg                    rising_r;
	reg [`HOLD_CNT_W-1:0]  hold_cnt_r;

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_line_high  <= 1'b0;
			o_slot_start <= 1'b0;
			rising_r     <= 1'b0;
			hold_cnt_r   <= {`HOLD_CNT_W{1'b0}};
		end else begin
			o_slot_start <= 1'b0;
			if (o_line_high) begin
				// hysteresis: only low threshold ends high
				if (i_below_low) begin
					o_line_high  <= 1'b0;
					o_slot_start <= 1'b1;
				end
			end else if (rising_r) begin
				if (i_below_low) begin
					rising_r   <= 1'b0;
					hold_cnt_r <= {`HOLD_CNT_W{1'b0}};
				end else if (hold_cnt_r == HOLD_END - 1'b1) begin
					rising_r    <= 1'b0;
					hold_cnt_r  <= {`HOLD_CNT_W{1'b0}};
					o_line_high <= 1'b1;
				end else begin
					hold_cnt_r <= hold_cnt_r + 1'b1;
				end
			end else if (i_above_high) begin
				rising_r   <= 1'b1;
				hold_cnt_r <= {`HOLD_CNT_W{1'b0}};
			end
		end
	end

endmodule // line_front_end

// File: rtl/rom_select_divider.v
// Selection commands, resume flag, front ends and oscillator divider
//
// Contract
// - Skip code enters function handling, no identifier
// - Resume code enters functions when flag set
// - Flag set only by successful selection
// - Repeated resumes allowed while flag set
// - Other device selected clears the flag
// - Receiver hysteresis ignores sags that stay above the low threshold
// - Early drop after rise restarts hold-off
// - Drop after hold-off starts new slot
// - After reset oscillator runs undivided
// - Divide by two, four, eight via either port
// - Divider scales slow timing, not slots
// - Unlock: skip, six bytes, CRC, two FF
// - Divide-by-two: skip, AA 85 41 02, CRC
// - Divide four/eight: bits, 2ms wait, CRC
// - Reset pulse answered by presence pulse
`timescale 1ns/1ps
`include "link_consts.vh"

module rom_select_divider #(
	parameter CFG_DELAY_CYC = `CFG_DELAY_CYC
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst_n,
	// Line comparators, one bit per port (0 = port A, 1 = port B)
	input  wire [1:0]  i_above_high,
	input  wire [1:0]  i_below_low,
	// Bit-slot layer events per port
	input  wire [1:0]  i_reset_seen,
	input  wire [1:0]  i_byte_valid,
	input  wire [15:0] i_byte,
	input  wire [1:0]  i_bit_valid,
	input  wire [1:0]  i_bit,
	// Outcome of identifier-based selection
	input  wire        i_select_ok,
	input  wire        i_select_other,
	// Undivided slow oscillator tick
	input  wire        i_osc_tick,
	// Front-end results
	output reg  [1:0]  o_line_high,
	output reg  [1:0]  o_slot_start,
	// Network layer results
	output reg  [1:0]  o_presence_req,
	output reg         o_func_go,
	output reg         o_func_port,
	output reg         o_reply_crc,
	output reg         o_reply_ff,
	output reg         o_resume_flag,
	// Oscillator divider
	output reg  [1:0]  o_div_sel,
	output reg         o_slow_tick
);

	localparam [3:0] ST_IDLE   = 4'h0;
	localparam [3:0] ST_ROM    = 4'h1;
	localparam [3:0] ST_FUNC   = 4'h2;
	localparam [3:0] ST_UNLOCK = 4'h3;
	localparam [3:0] ST_SET    = 4'h4;
	localparam [3:0] ST_TAIL   = 4'h5;
	localparam [3:0] ST_BITS   = 4'h6;
	localparam [3:0] ST_DELAY  = 4'h7;
	localparam [3:0] ST_LAST   = 4'h8;
	localparam [3:0] ST_IGNORE = 4'h9;
	localparam [3:0] ST_ACTIVE = 4'hA;

	localparam [`DELAY_CNT_W-1:0] DELAY_END =
		CFG_DELAY_CYC[`DELAY_CNT_W-1:0];
	localparam [6:0]              BIT_PATTERN = `BIT_SEQ;
	wire [1:0] fe_high;
	wire [1:0] fe_slot;

	reg [3:0]              state_r;
	reg [3:0]              state_nxt;
	reg                    act_r;
	reg [2:0]              idx_r;
	reg [2:0]              idx_nxt;
	reg                    unlock_r;
	reg                    unlock_nxt;
	reg [1:0]              pend_r;
	reg [1:0]              pend_nxt;
	reg [`DELAY_CNT_W-1:0] dly_r;
	reg [2:0]              tick_cnt_r;
	reg                    apply_nxt;
	reg                    func_nxt;
	reg                    crc_nxt;
	reg                    ff_nxt;
	reg [7:0]              unlock_byte;

	wire       byte_v = i_byte_valid[act_r];
	wire [7:0] byte_d = act_r ? i_byte[15:8] : i_byte[7:0];
	wire       bit_v  = i_bit_valid[act_r];
	wire       bit_d  = i_bit[act_r];
	wire       any_rst = |i_reset_seen;
	wire       dly_done = (dly_r == DELAY_END);

	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_port
			line_front_end u_fe (
				.i_clk        (i_clk),
				.i_rst_n      (i_rst_n),
				.i_above_high (i_above_high[p]),
				.i_below_low  (i_below_low[p]),
				.o_line_high  (fe_high[p]),
				.o_slot_start (fe_slot[p])
			);
		end
	endgenerate

	always @* begin
		case (idx_r)
		3'h0:    unlock_byte = `UNLOCK_B0;
		3'h1:    unlock_byte = `UNLOCK_B1;
		3'h2:    unlock_byte = `UNLOCK_B2;
		3'h3:    unlock_byte = `UNLOCK_B3;
		3'h4:    unlock_byte = `UNLOCK_B4;
		default: unlock_byte = `UNLOCK_B5;
		endcase
	end

	always @* begin
		state_nxt  = state_r;
		idx_nxt    = idx_r;
		unlock_nxt = unlock_r;
		pend_nxt   = pend_r;
		apply_nxt  = 1'b0;
		func_nxt   = 1'b0;
		crc_nxt    = 1'b0;
		ff_nxt     = 1'b0;
		case (state_r)
		ST_IDLE: begin
		end
		ST_ROM: begin
			if (byte_v) begin
				idx_nxt = 3'h0;
				if (byte_d == `CMD_SKIP) begin
					state_nxt = ST_FUNC;
					func_nxt  = 1'b1;
				end else if (byte_d == `CMD_RESUME) begin
					if (o_resume_flag) begin
						state_nxt = ST_ACTIVE;
						func_nxt  = 1'b1;
					end else begin
						state_nxt = ST_IGNORE;
					end
				end else begin
					// Other ROM commands belong to another layer
					state_nxt = ST_IGNORE;
				end
			end
		end
		ST_FUNC: begin
			if (byte_v) begin
				if (byte_d == `UNLOCK_B0) begin
					state_nxt = ST_UNLOCK;
					idx_nxt   = 3'h1;
				end else if (byte_d == `SET_B0 && unlock_r) begin
					state_nxt = ST_SET;
				end else begin
					state_nxt = ST_ACTIVE;
				end
			end
		end
		ST_UNLOCK: begin
			if (byte_v) begin
				if (byte_d != unlock_byte) begin
					state_nxt = ST_ACTIVE;
				end else if (idx_r == `UNLOCK_LEN - 1'b1) begin
					state_nxt  = ST_ACTIVE;
					unlock_nxt = 1'b1;
					crc_nxt    = 1'b1;
					ff_nxt     = 1'b1;
				end else begin
					idx_nxt = idx_r + 1'b1;
				end
			end
		end
		ST_SET: begin
			if (byte_v) begin
				if (idx_r == 3'h0) begin
					if (byte_d == `SET_B1)
						idx_nxt = 3'h1;
					else
						state_nxt = ST_ACTIVE;
				end else begin
					idx_nxt = 3'h0;
					case (byte_d)
					`SET_DIVIDE_BY_TWO: begin
						pend_nxt  = `DIV_TWO;
						state_nxt = ST_TAIL;
					end
					`SET_DIVIDE_BY_FOUR: begin
						pend_nxt  = `DIV_FOUR;
						state_nxt = ST_BITS;
					end
					`SET_DIVIDE_BY_EIGHT: begin
						pend_nxt  = `DIV_EIGHT;
						state_nxt = ST_BITS;
					end
					default: state_nxt = ST_ACTIVE;
					endcase
				end
			end
		end
		ST_TAIL: begin
			if (byte_v) begin
				state_nxt = ST_ACTIVE;
				if (byte_d == `SET_DIVIDE_BY_TWO_TAIL) begin
					apply_nxt  = 1'b1;
					crc_nxt    = 1'b1;
					unlock_nxt = 1'b0;
				end
			end
		end
		ST_BITS: begin
			if (byte_v) begin
				state_nxt = ST_ACTIVE;
			end else if (bit_v) begin
				if (bit_d != BIT_PATTERN[idx_r]) begin
					state_nxt = ST_ACTIVE;
				end else if (idx_r == `BIT_SEQ_LEN - 1'b1) begin
					state_nxt = ST_DELAY;
				end else begin
					idx_nxt = idx_r + 1'b1;
				end
			end
		end
		ST_DELAY: begin
			if (bit_v || byte_v)
				state_nxt = ST_ACTIVE;
			else if (dly_done)
				state_nxt = ST_LAST;
		end
		ST_LAST: begin
			if (byte_v) begin
				state_nxt = ST_ACTIVE;
			end else if (bit_v) begin
				state_nxt = ST_ACTIVE;
				if (!bit_d) begin
					apply_nxt  = 1'b1;
					crc_nxt    = 1'b1;
					unlock_nxt = 1'b0;
				end
			end
		end
		ST_IGNORE: begin
		end
		ST_ACTIVE: begin
		end
		default: state_nxt = ST_IDLE;
		endcase
		if (any_rst) begin
			state_nxt = ST_ROM;
			idx_nxt   = 3'h0;
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_r        <= ST_IDLE;
			act_r          <= 1'b0;
			idx_r          <= 3'h0;
			unlock_r       <= 1'b0;
			pend_r         <= `DIV_ONE;
			dly_r          <= {`DELAY_CNT_W{1'b0}};
			o_line_high    <= 2'h0;
			o_slot_start   <= 2'h0;
			o_presence_req <= 2'h0;
			o_func_go      <= 1'b0;
			o_func_port    <= 1'b0;
			o_reply_crc    <= 1'b0;
			o_reply_ff     <= 1'b0;
			o_resume_flag  <= 1'b0;
		end else begin
			state_r        <= state_nxt;
			idx_r          <= idx_nxt;
			unlock_r       <= unlock_nxt;
			pend_r         <= pend_nxt;
			o_line_high    <= fe_high;
			o_slot_start   <= fe_slot;
			o_presence_req <= i_reset_seen;
			o_func_go      <= func_nxt;
			o_func_port    <= act_r;
			o_reply_crc    <= crc_nxt;
			o_reply_ff     <= ff_nxt;
			// Port A wins when both ports reset together
			if (i_reset_seen[0])
				act_r <= 1'b0;
			else if (i_reset_seen[1])
				act_r <= 1'b1;
			// Delay counts only while waiting, saturating at the end
			if (state_r != ST_DELAY)
				dly_r <= {`DELAY_CNT_W{1'b0}};
			else if (!dly_done)
				dly_r <= dly_r + 1'b1;
			if (i_select_ok)
				o_resume_flag <= 1'b1;
			else if (i_select_other)
				o_resume_flag <= 1'b0;
		end
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_div_sel   <= `DIV_ONE;
			tick_cnt_r  <= 3'h0;
			o_slow_tick <= 1'b0;
		end else begin
			if (apply_nxt)
				o_div_sel <= pend_nxt;
			// only slow-clock users see the divided tick
			o_slow_tick <= 1'b0;
			if (i_osc_tick) begin
				if (tick_cnt_r >= ((3'h1 << o_div_sel) - 3'h1)) begin
					tick_cnt_r  <= 3'h0;
					o_slow_tick <= 1'b1;
				end else begin
					tick_cnt_r <= tick_cnt_r + 3'h1;
				end
			end
		end
	end

endmodule // rom_select_divider

// File: tb/link_ctrl_model.sv
// Bus controller model feeding bit-slot layer events
`timescale 1ns/1ps
module link_ctrl_model #(
	parameter int DLY = 20
) (
	// Clock and events
	input  wire         i_clk,
	output logic [1:0]  o_reset_seen = 2'h0,
	output logic [1:0]  o_byte_valid = 2'h0,
	output logic [15:0] o_byte = 16'h0000,
	output logic [1:0]  o_bit_valid = 2'h0,
	output logic [1:0]  o_bit = 2'h0
);
	logic [7:0] ul [6] = '{8'hDD, 8'h01, 8'h3D, 8'h75, 8'hF9, 8'hC3};
	task rp(input int p);
		@(negedge i_clk) o_reset_seen[p] = 1'b1;
		@(negedge i_clk) o_reset_seen[p] = 1'b0;
		repeat (2) @(negedge i_clk);
	endtask
	task tx(input int p, input logic [7:0] b);
		@(negedge i_clk) o_byte_valid[p] = 1'b1;
		o_byte[p*8 +: 8] = b;
		@(negedge i_clk) o_byte_valid[p] = 1'b0;
		// Released lines must not keep the last byte
		o_byte = ~o_byte;
		repeat (2) @(negedge i_clk);
	endtask
	task tbit(input int p, input logic b);
		@(negedge i_clk) o_bit_valid[p] = 1'b1;
		o_bit[p] = b;
		@(negedge i_clk) o_bit_valid[p] = 1'b0;
		o_bit = ~o_bit;
	endtask
	task sel(input int p);
		rp(p);
		tx(p, 8'hCC);
	endtask
	task unlock(input int p);
		sel(p);
		foreach (ul[i]) tx(p, ul[i]);
		repeat (4) @(negedge i_clk);
	endtask
	task setdiv(input int p, input logic [7:0] c, input bit early);
		sel(p);
		tx(p, 8'hAA);
		tx(p, 8'h85);
		tx(p, c);
		if (c == 8'h41) tx(p, 8'h02);
		else begin
			for (int i = 0; i < 7; i++) tbit(p, i == 1);
			repeat (early ? 3 : DLY + 5) @(negedge i_clk);
			tbit(p, 1'b0);
		end
		repeat (4) @(negedge i_clk);
	endtask
endmodule // link_ctrl_model

// File: tb/rom_select_divider_properties.sv
// Port checks for the selection and divider block
`timescale 1ns/1ps
module rom_select_divider_properties (
	// Observed ports
	input wire        i_clk,
	input wire        i_rst_n,
	input wire [1:0]  i_below_low,
	input wire [1:0]  i_reset_seen,
	input wire [1:0]  i_byte_valid,
	input wire [15:0] i_byte,
	input wire        i_select_ok,
	input wire [1:0]  o_line_high,
	input wire [1:0]  o_slot_start,
	input wire [1:0]  o_presence_req,
	input wire        o_func_go,
	input wire        o_func_port,
	input wire        o_reply_crc,
	input wire        o_resume_flag,
	input wire [1:0]  o_div_sel
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// ROM byte still awaited on port A
	logic wait_a_r;
	always @(posedge i_clk) begin
		if (!i_rst_n)
			wait_a_r <= 1'b0;
		else if (|i_reset_seen)
			wait_a_r <= i_reset_seen[0];
		else if (|i_byte_valid)
			wait_a_r <= 1'b0;
	end
	sequence rom_byte(logic [7:0] c);
		wait_a_r && i_byte_valid[0] && i_byte[7:0] == c;
	endsequence
	sequence stay_low;
		(!o_line_high[0]) [*8];
	endsequence
	a_presence_on_reset: assert property (
		i_reset_seen[0] |=> o_presence_req[0]) else $error("no presence");
	a_skip_enters_func: assert property (
		rom_byte(8'hCC) |=> o_func_go && !o_func_port) else $error("skip");
	a_resume_by_flag: assert property (
		rom_byte(8'hA5) |=> o_func_go == $past(o_resume_flag))
		else $error("resume");
	a_flag_set_only: assert property (
		$rose(o_resume_flag) |-> $past(i_select_ok)) else $error("flag");
	a_div_after_reset: assert property (
		$rose(i_rst_n) |-> o_div_sel == 2'h0) else $error("div reset");
	a_div_with_crc: assert property (
		$changed(o_div_sel) |-> o_reply_crc) else $error("div change");
	a_slot_after_drop: assert property (
		$rose(i_below_low[0]) && o_line_high[0] |-> ##2 o_slot_start[0])
		else $error("slot missing");
	a_hold_off_restart: assert property (
		i_below_low[0] |-> ##2 stay_low) else $error("hold-off");
endmodule // rom_select_divider_properties

bind rom_select_divider rom_select_divider_properties i_props (
	.i_clk, .i_rst_n, .i_below_low, .i_reset_seen, .i_byte_valid,
	.i_byte, .i_select_ok, .o_line_high, .o_slot_start, .o_presence_req,
	.o_func_go, .o_func_port, .o_reply_crc, .o_resume_flag, .o_div_sel
);

// File: tb/tb_rom_select_divider.sv
// Self-checking bench for the selection and divider block
`timescale 1ns/1ps
module tb_rom_select_divider;
	localparam int DLY = 20;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [1:0]  i_above_high = 2'h0;
	logic [1:0]  i_below_low = 2'h0;
	logic        i_select_ok = 1'b0;
	logic        i_select_other = 1'b0;
	logic        i_osc_tick = 1'b0;
	wire  [1:0]  i_reset_seen, i_byte_valid, i_bit_valid, i_bit;
	wire  [15:0] i_byte;
	wire  [1:0]  o_line_high, o_slot_start, o_presence_req, o_div_sel;
	wire         o_func_go, o_func_port, o_reply_crc, o_reply_ff;
	wire         o_resume_flag, o_slow_tick;
	int          bad_count, n_compared, n_go, n_crc, n_ff, n_slot, n_tk, s;
	int          n_pr, t;
	logic        last_port;
	logic [1:0]  last_pr;
	logic [1:0]  cur = 2'h0;
	logic [7:0]  b;
	always #5 i_clk = ~i_clk;
	link_ctrl_model #(.DLY(DLY)) i_ctrl (.i_clk, .o_reset_seen(i_reset_seen),
		.o_byte_valid(i_byte_valid), .o_byte(i_byte),
		.o_bit_valid(i_bit_valid), .o_bit(i_bit));
	rom_select_divider #(.CFG_DELAY_CYC(DLY)) i_dut (.i_clk, .i_rst_n,
		.i_above_high, .i_below_low, .i_reset_seen, .i_byte_valid, .i_byte,
		.i_bit_valid, .i_bit, .i_select_ok, .i_select_other, .i_osc_tick,
		.o_line_high, .o_slot_start, .o_presence_req, .o_func_go,
		.o_func_port, .o_reply_crc, .o_reply_ff, .o_resume_flag,
		.o_div_sel, .o_slow_tick);
	always @(posedge i_clk) begin
		n_go += (o_func_go === 1'b1);
		n_crc += (o_reply_crc === 1'b1);
		n_ff += (o_reply_ff === 1'b1);
		n_slot += (o_slot_start !== 2'h0);
		n_tk += (o_slow_tick === 1'b1);
		n_pr += (o_presence_req !== 2'h0);
		if (o_presence_req !== 2'h0)
			last_pr <= o_presence_req;
		if (o_func_go === 1'b1)
			last_port <= o_func_port;
	end
	function automatic logic [1:0] div_of(input logic [7:0] c);
		return c[1:0];
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		n_compared++;
		if (seen !== ex) begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, ex, seen);
		end
	endtask
	task end_of_test();
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task rise_drop(input int p, input int k);
		@(negedge i_clk) i_above_high[p] = 1'b1;
		repeat (k) @(negedge i_clk);
		// Sag that never reaches the low threshold
		i_above_high[p] = 1'b0;
		repeat (3) @(negedge i_clk);
		if (k > 12) chk("sag level", o_line_high[p], 1'b1);
		i_below_low[p] = 1'b1;
		@(negedge i_clk) i_below_low[p] = 1'b0;
		repeat (3) @(negedge i_clk);
	endtask
	task ticks();
		s = n_tk;
		repeat (16) begin
			@(negedge i_clk) i_osc_tick = 1'b1;
			@(negedge i_clk) i_osc_tick = 1'b0;
		end
		repeat (3) @(negedge i_clk);
		chk("slow ticks", n_tk - s, 16 >> cur);
	endtask
	task div_case(input int p, input logic [7:0] c, input bit early);
		s = n_ff;
		i_ctrl.unlock(p);
		chk("unlock ff", n_ff - s, 1);
		s = n_crc;
		i_ctrl.setdiv(p, c, early);
		if (!early) cur = div_of(c);
		chk("set crc", n_crc - s, !early);
		chk("div", o_div_sel, cur);
		ticks();
	endtask
	initial begin
		void'($urandom(35819));
		repeat (8) @(negedge i_clk);
		i_rst_n = 1'b1;
		@(negedge i_clk);
		chk("div start", o_div_sel, 2'h0);
		chk("flag start", o_resume_flag, 1'b0);
		for (int p = 0; p < 2; p++) begin
			repeat (4) begin
				s = n_slot;
				rise_drop(p, 1 + $urandom_range(4));
				chk("glitch slot", n_slot - s, 0);
				chk("glitch level", o_line_high[p], 1'b0);
			end
			s = n_slot;
			rise_drop(p, 15);
			chk("slot", n_slot - s, 1);
			s = n_go;
			t = n_pr;
			i_ctrl.sel(p);
			chk("presence", n_pr - t, 1);
			chk("presence port", last_pr, 2'h1 << p);
			chk("skip go", n_go - s, 1);
			chk("skip port", last_port, p[0]);
			chk("skip flag", o_resume_flag, 1'b0);
		end
		s = n_go;
		i_ctrl.rp(1);
		i_ctrl.tx(1, 8'hA5);
		i_ctrl.tx(1, 8'hCC);
		chk("resume clear", n_go - s, 0);
		@(negedge i_clk) i_select_ok = 1'b1;
		@(negedge i_clk) i_select_ok = 1'b0;
		chk("flag set", o_resume_flag, 1'b1);
		// Resumes alternate ports so both see the set flag
		for (int k = 0; k < 3; k++) begin
			i_ctrl.rp(k != 1);
			i_ctrl.tx(k != 1, 8'hA5);
		end
		chk("resumes", n_go - s, 3);
		chk("resume port", last_port, 1'b1);
		@(negedge i_clk) i_select_other = 1'b1;
		@(negedge i_clk) i_select_other = 1'b0;
		chk("flag clear", o_resume_flag, 1'b0);
		// First refused code is a resume, the rest are random
		for (int k = 0; k < 5; k++) begin
			b = (k == 0) ? 8'hA5 : 8'($urandom);
			if (b == 8'hCC) b = 8'hA5;
			s = n_go;
			i_ctrl.rp(0);
			i_ctrl.tx(0, b);
			i_ctrl.tx(0, 8'hCC);
			chk("refused go", n_go - s, 0);
		end
		div_case(0, 8'h41, 1'b0);
		div_case(1, 8'h42, 1'b0);
		div_case(0, 8'h43, 1'b1);
		div_case(1, 8'h43, 1'b0);
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_clk);
		i_rst_n = 1'b1;
		cur = 2'h0;
		@(negedge i_clk);
		chk("div por", o_div_sel, cur);
		ticks();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		end_of_test();
	end
endmodule // tb_rom_select_divider
